/* rtl/adc_trig_pkg.sv */
/*
 * Constants shared by the converter control slice: register offsets,
 * field positions, reset values and the trigger source codes.
 * Assumes an 8-bit register port with a 4-bit word address.
 */
package adc_trig_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CHANNEL_GO = 4'h0; // Channel, go, enable
    localparam logic [3:0] ADDR_FORMAT     = 4'h1; // Format, clock, ref
    localparam logic [3:0] ADDR_TRIGGER    = 4'h2; // Trigger source
    localparam logic [3:0] ADDR_RES_HIGH   = 4'h3; // Result high byte
    localparam logic [3:0] ADDR_RES_LOW    = 4'h4; // Result low byte
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5; // Sticky events, RO
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h6; // Event enables
    localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h7; // Write one to clear

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ON_BIT       = 0;  // Converter on
    localparam int GO_BIT       = 1;  // Conversion in progress
    localparam int CHAN_LSB     = 2;  // Input channel select, 5 bits
    localparam int CHAN_MSB     = 6;
    localparam int JUSTIFY_BIT  = 7;  // 1 = right, 0 = left
    localparam int CLKSEL_LSB   = 4;  // Conversion clock select, 3 bits
    localparam int CLKSEL_MSB   = 6;
    localparam int REFSEL_LSB   = 0;  // Positive reference, 2 bits
    localparam int REFSEL_MSB   = 1;
    localparam int TRIG_LSB     = 4;  // Trigger source select, 4 bits
    localparam int TRIG_MSB     = 7;
    localparam int EV_DONE      = 0;  // Event: conversion finished
    localparam int EV_TRIG      = 1;  // Event: hardware trigger start
    localparam int EV_COUNT     = 2;
    localparam int PWM_UNITS    = 3;
    localparam int PWM_MATCHES  = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [3:0] ZERO_NIBBLE  = 4'h0;
    localparam logic [5:0] ZERO_SIX     = 6'h00;

    // ------------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TRIG_NONE      = 4'b0000,
        TRIG_PWM1_IRQ  = 4'b0001,
        TRIG_PWM2_IRQ  = 4'b0010,
        TRIG_TMR1_ROLL = 4'b0011,
        TRIG_TMR2_ROLL = 4'b0100,
        TRIG_TMR3_PER  = 4'b0101,
        TRIG_CMP_SYNC  = 4'b0110,
        TRIG_PWM3_IRQ  = 4'b0111,
        TRIG_PWM1_OFS  = 4'b1000,
        TRIG_PWM2_OFS  = 4'b1001,
        TRIG_PWM3_OFS  = 4'b1010
    } trig_code_type;

endpackage : adc_trig_pkg

/* rtl/adc_trigger_and_result_format.sv */
/*
 * Converter control slice: trigger source selection with rising edge
 * start, conversion-in-progress bit, result justification into two
 * result bytes, register port and event interrupt.
 * Assumes trigger sources, the converter core and the register master
 * all run on clk; the core takes a start pulse and returns a done
 * pulse with the 10-bit result beside it.
 */
`timescale 1ns/10ps

module adc_trigger_and_result_format (
    input  wire logic       clk,                      // System clock
    input  wire logic       nrst,                     // Async reset, low
    // Register port
    input  wire logic [3:0] reg_addr,                 // Word address
    input  wire logic [7:0] reg_wdata,                // Write data
    input  wire logic       reg_write,                // Write strobe
    input  wire logic       reg_read,                 // Read strobe
    output logic      [7:0] reg_rdata,                // Read data, +1
    // Trigger sources
    input  wire logic       first_timer_rollover,     // Timer 1 wrap
    input  wire logic       second_timer_rollover,    // Timer 2 wrap
    input  wire logic       third_timer_period_match, // Timer 3 period
    input  wire logic       comparator_synced_output, // Comparator out
    input  wire logic [3:0] pwm_unit1_match,          // Unit 1 matches
    input  wire logic [3:0] pwm_unit2_match,          // Unit 2 matches
    input  wire logic [3:0] pwm_unit3_match,          // Unit 3 matches
    input  wire logic [3:0] pwm_unit1_irq_enable_set, // Unit 1 enables
    input  wire logic [3:0] pwm_unit2_irq_enable_set, // Unit 2 enables
    input  wire logic [3:0] pwm_unit3_irq_enable_set, // Unit 3 enables
    input  wire logic       pwm_unit1_offset_hit,     // Unit 1 offset
    input  wire logic       pwm_unit2_offset_hit,     // Unit 2 offset
    input  wire logic       pwm_unit3_offset_hit,     // Unit 3 offset
    // Converter core
    input  wire logic       conv_done,                // Result valid
    input  wire logic [9:0] conversion_result,        // 10-bit result
    output logic            conv_start,               // Start pulse
    output logic            converter_on,             // Core enable
    output logic      [4:0] input_channel_select,     // Analog channel
    output logic      [2:0] conversion_clock_select,  // Core clock
    output logic      [1:0] positive_reference_select,// Reference
    // Timer flag sets and interrupt
    output logic            first_timer_flag_set,     // Timer 1 flag
    output logic            second_timer_flag_set,    // Timer 2 flag
    output logic            irq                       // Level interrupt
);

    // --------------------
    // Declarations
    // --------------------
    logic                              go;               // In progress
    logic                              result_justify_select; // 1=right
    adc_trig_pkg::trig_code_type       trigger_source_select; // Source
    logic [7:0]                        result_high;      // Result high
    logic [7:0]                        result_low;       // Result low
    logic [adc_trig_pkg::EV_COUNT-1:0] irq_status;       // Sticky events
    logic [adc_trig_pkg::EV_COUNT-1:0] irq_enable;       // Event enables
    logic                              trig_now;         // Source sample
    logic                              trig_prev;        // Prior sample
    logic                              go_prev;          // Prior go

    logic [adc_trig_pkg::PWM_UNITS-1:0] pwm_irq;         // Unit irq
    logic [adc_trig_pkg::PWM_UNITS-1:0] pwm_ofs;         // Unit offset
    logic [adc_trig_pkg::PWM_MATCHES-1:0] pwm_match [3]; // Matches
    logic [adc_trig_pkg::PWM_MATCHES-1:0] pwm_en    [3]; // Enables

    logic       sel_source;      // Selected trigger level
    logic       trig_edge;       // Rising edge pulse
    logic       hw_start;        // Edge accepted as start
    logic       wr_chan;         // Write decodes
    logic       wr_fmt;
    logic       wr_trig;
    logic       wr_high;
    logic       wr_low;
    logic       wr_clear;
    logic       wr_enable;
    logic       next_go;         // Next in-progress value
    logic [7:0] chan_byte;       // Read views
    logic [7:0] fmt_byte;
    logic [7:0] trig_byte;
    logic [7:0] next_rdata;      // Read mux
    logic [7:0] load_high;       // Justified result bytes
    logic [7:0] load_low;
    logic [adc_trig_pkg::EV_COUNT-1:0] ev_set;   // Event pulses
    logic [adc_trig_pkg::EV_COUNT-1:0] ev_clr;   // Clear mask
    logic [adc_trig_pkg::EV_COUNT-1:0] next_status;

    // --------------------
    // PWM unit trigger combining
    // --------------------
    assign pwm_match[0] = pwm_unit1_match;
    assign pwm_match[1] = pwm_unit2_match;
    assign pwm_match[2] = pwm_unit3_match;
    assign pwm_en[0]    = pwm_unit1_irq_enable_set;
    assign pwm_en[1]    = pwm_unit2_irq_enable_set;
    assign pwm_en[2]    = pwm_unit3_irq_enable_set;
    assign pwm_ofs      = {pwm_unit3_offset_hit, pwm_unit2_offset_hit,
                           pwm_unit1_offset_hit};

    // Any enabled match of a unit raises that unit's interrupt
    genvar u;
    generate
        for (u = 0; u < adc_trig_pkg::PWM_UNITS; u++) begin : g_pwm
            assign pwm_irq[u] = |(pwm_match[u] & pwm_en[u]);
        end
    endgenerate

    // --------------------
    // Trigger source selection
    // --------------------
    // Selects one level; zero and reserved codes select nothing
    // Rollovers feed the start and still raise their own flags
    always_comb begin
        case (trigger_source_select)
            adc_trig_pkg::TRIG_NONE:      sel_source = 1'b0;
            adc_trig_pkg::TRIG_PWM1_IRQ:  sel_source = pwm_irq[0];
            adc_trig_pkg::TRIG_PWM2_IRQ:  sel_source = pwm_irq[1];
            adc_trig_pkg::TRIG_PWM3_IRQ:  sel_source = pwm_irq[2];
            adc_trig_pkg::TRIG_TMR1_ROLL: sel_source =
                                          first_timer_rollover;
            adc_trig_pkg::TRIG_TMR2_ROLL: sel_source =
                                          second_timer_rollover;
            adc_trig_pkg::TRIG_TMR3_PER:  sel_source =
                                          third_timer_period_match;
            adc_trig_pkg::TRIG_CMP_SYNC:  sel_source =
                                          comparator_synced_output;
            adc_trig_pkg::TRIG_PWM1_OFS:  sel_source = pwm_ofs[0];
            adc_trig_pkg::TRIG_PWM2_OFS:  sel_source = pwm_ofs[1];
            adc_trig_pkg::TRIG_PWM3_OFS:  sel_source = pwm_ofs[2];
            default:                      sel_source = 1'b0;
        endcase
    end

    // Edge detector: only a low-to-high step counts, never a level
    assign trig_edge = trig_now & ~trig_prev;
    // Accepted only while the converter is on
    assign hw_start  = trig_edge & converter_on;

    // Samples the selected source each clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trig_now  <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_now  <= sel_source;
            trig_prev <= trig_now;
        end
    end

    // --------------------
    // Register write decode
    // --------------------
    // One strobe, one register, no wait states
    assign wr_chan   = reg_write && reg_addr == adc_trig_pkg::ADDR_CHANNEL_GO;
    assign wr_fmt    = reg_write && reg_addr == adc_trig_pkg::ADDR_FORMAT;
    assign wr_trig   = reg_write && reg_addr == adc_trig_pkg::ADDR_TRIGGER;
    assign wr_high   = reg_write && reg_addr == adc_trig_pkg::ADDR_RES_HIGH;
    assign wr_low    = reg_write && reg_addr == adc_trig_pkg::ADDR_RES_LOW;
    assign wr_clear  = reg_write && reg_addr == adc_trig_pkg::ADDR_IRQ_CLEAR;
    assign wr_enable = reg_write && reg_addr == adc_trig_pkg::ADDR_IRQ_ENABLE;

    // --------------------
    // Conversion-in-progress bit
    // --------------------
    // Software write loads; done clears over it; trigger edge sets and wins
    always_comb begin
        next_go = go;
        if (wr_chan) begin
            next_go = reg_wdata[adc_trig_pkg::GO_BIT];
        end
        if (conv_done) begin
            next_go = 1'b0;
        end
        if (hw_start) begin
            next_go = 1'b1;
        end
    end

    // Control registers, cleared on reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            go                        <= 1'b0;
            go_prev                   <= 1'b0;
            converter_on              <= 1'b0;
            input_channel_select      <= 5'h00;
            result_justify_select     <= 1'b0;
            conversion_clock_select   <= 3'h0;
            positive_reference_select <= 2'h0;
            trigger_source_select     <= adc_trig_pkg::TRIG_NONE;
        end else begin
            go      <= next_go;
            go_prev <= go;
            if (wr_chan) begin
                converter_on         <= reg_wdata[adc_trig_pkg::ON_BIT];
                input_channel_select <=
                    reg_wdata[adc_trig_pkg::CHAN_MSB:adc_trig_pkg::CHAN_LSB];
            end
            if (wr_fmt) begin
                result_justify_select <=
                    reg_wdata[adc_trig_pkg::JUSTIFY_BIT];
                conversion_clock_select <=
                    reg_wdata[adc_trig_pkg::CLKSEL_MSB:
                              adc_trig_pkg::CLKSEL_LSB];
                positive_reference_select <=
                    reg_wdata[adc_trig_pkg::REFSEL_MSB:
                              adc_trig_pkg::REFSEL_LSB];
            end
            if (wr_trig) begin
                trigger_source_select <= adc_trig_pkg::trig_code_type'(
                    reg_wdata[adc_trig_pkg::TRIG_MSB:
                              adc_trig_pkg::TRIG_LSB]);
            end
        end
    end

    // --------------------
    // Result formatting
    // --------------------
    // Right: top six high bits zero; left: bottom six low bits zero
    assign load_high = result_justify_select ?
        {adc_trig_pkg::ZERO_SIX, conversion_result[9:8]} :
        conversion_result[9:2];
    assign load_low  = result_justify_select ?
        conversion_result[7:0] :
        {conversion_result[1:0], adc_trig_pkg::ZERO_SIX};

    // A finished conversion beats a software write
    // Result bytes: no reset, so contents survive every reset
    always_ff @(posedge clk) begin
        if (conv_done) begin
            result_high <= load_high;
            result_low  <= load_low;
        end else begin
            if (wr_high) begin
                result_high <= reg_wdata;
            end
            if (wr_low) begin
                result_low <= reg_wdata;
            end
        end
    end

    // --------------------
    // Events and interrupt
    // --------------------
    // Done and accepted trigger starts are the events
    assign ev_set[adc_trig_pkg::EV_DONE] = conv_done;
    assign ev_set[adc_trig_pkg::EV_TRIG] = hw_start;
    assign ev_clr      = wr_clear ?
        reg_wdata[adc_trig_pkg::EV_COUNT-1:0] : '0;
    assign next_status = (irq_status & ~ev_clr) | ev_set; // Set wins

    // Sticky status, enables and registered interrupt level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
            irq_enable <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_enable) begin
                irq_enable <= reg_wdata[adc_trig_pkg::EV_COUNT-1:0];
            end
            // Level from the next status, so it tracks the flags
            irq <= |(next_status & irq_enable);
        end
    end

    // --------------------
    // Core start and timer flag pass-through
    // --------------------
    // Start pulse on every rise of the in-progress bit; rollovers keep
    // raising their own timer flags whatever the trigger selection
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_start            <= 1'b0;
            first_timer_flag_set  <= 1'b0;
            second_timer_flag_set <= 1'b0;
        end else begin
            conv_start            <= go & ~go_prev;
            first_timer_flag_set  <= first_timer_rollover;
            second_timer_flag_set <= second_timer_rollover;
        end
    end

    // --------------------
    // Register read
    // --------------------
    // Unused bits of each view read zero
    assign chan_byte = {1'b0, input_channel_select, go, converter_on};
    assign fmt_byte  = {result_justify_select, conversion_clock_select,
                        2'b00, positive_reference_select};
    assign trig_byte = {trigger_source_select,
                        adc_trig_pkg::ZERO_NIBBLE};

    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        case (reg_addr)
            adc_trig_pkg::ADDR_CHANNEL_GO: next_rdata = chan_byte;
            adc_trig_pkg::ADDR_FORMAT:     next_rdata = fmt_byte;
            adc_trig_pkg::ADDR_TRIGGER:    next_rdata = trig_byte;
            adc_trig_pkg::ADDR_RES_HIGH:   next_rdata = result_high;
            adc_trig_pkg::ADDR_RES_LOW:    next_rdata = result_low;
            adc_trig_pkg::ADDR_IRQ_STATUS:
                next_rdata = {6'h00, irq_status};
            adc_trig_pkg::ADDR_IRQ_ENABLE:
                next_rdata = {6'h00, irq_enable};
            default:
                next_rdata = adc_trig_pkg::RESET_BYTE;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= adc_trig_pkg::RESET_BYTE;
        end else begin
            reg_rdata <= reg_read ? next_rdata : adc_trig_pkg::RESET_BYTE;
        end
    end

endmodule : adc_trigger_and_result_format

/* tb/adc_trig_properties.sv */
/*
 * Port checker for the converter control slice.
 * Assumes one clock, clk, and the async active-low reset nrst.
 */
`timescale 1ns/10ps
module adc_trig_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       first_timer_rollover,
    input wire logic       second_timer_rollover,
    input wire logic       third_timer_period_match,
    input wire logic       comparator_synced_output,
    input wire logic [3:0] pwm_unit1_match,
    input wire logic [3:0] pwm_unit2_match,
    input wire logic [3:0] pwm_unit3_match,
    input wire logic [3:0] pwm_unit1_irq_enable_set,
    input wire logic [3:0] pwm_unit2_irq_enable_set,
    input wire logic [3:0] pwm_unit3_irq_enable_set,
    input wire logic       pwm_unit1_offset_hit,
    input wire logic       pwm_unit2_offset_hit,
    input wire logic       pwm_unit3_offset_hit,
    input wire logic       conv_start,
    input wire logic       converter_on,
    input wire logic       first_timer_flag_set,
    input wire logic       second_timer_flag_set
);
    // --------------------
    // Helper logic
    // --------------------
    logic [3:0]  trig_sel; // Copy of the trigger field
    logic [15:0] srcs;     // Sources indexed by trigger code
    logic        sel_src;  // Source picked by the copy
    logic        sw_go;    // Software write that sets go
    assign sw_go = reg_write && reg_wdata[adc_trig_pkg::GO_BIT]
                   && reg_addr == adc_trig_pkg::ADDR_CHANNEL_GO;
    assign srcs = {5'h00, pwm_unit3_offset_hit, pwm_unit2_offset_hit,
        pwm_unit1_offset_hit, |(pwm_unit3_match & pwm_unit3_irq_enable_set),
        comparator_synced_output, third_timer_period_match,
        second_timer_rollover, first_timer_rollover,
        |(pwm_unit2_match & pwm_unit2_irq_enable_set),
        |(pwm_unit1_match & pwm_unit1_irq_enable_set), 1'b0};
    assign sel_src = srcs[trig_sel];
    // Follows software writes of the trigger field
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            trig_sel <= 4'h0;
        else if (reg_write && reg_addr == adc_trig_pkg::ADDR_TRIGGER)
            trig_sel <= reg_wdata[7:4];
    end
    // --------------------
    // Properties
    // --------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_trig_readback: assert property (
        reg_read && reg_addr == adc_trig_pkg::ADDR_TRIGGER
        |=> reg_rdata == {$past(trig_sel), 4'h0})
        else $error("bad trigger readback");
    a_start_on_edge: assert property (
        conv_start && !$past(sw_go, 2)
        |-> $past(sel_src, 3) && !$past(sel_src, 4))
        else $error("start without edge");
    a_zero_code: assert property (
        conv_start && !$past(sw_go, 2) |-> $past(trig_sel, 3) != 4'h0)
        else $error("start while disabled");
    a_on_gates: assert property (
        conv_start && !$past(sw_go, 2) |-> $past(converter_on, 3))
        else $error("start while off");
    a_start_pulse: assert property (
        conv_start |=> !conv_start)
        else $error("long start pulse");
    a_flag_one: assert property (
        first_timer_rollover |=> first_timer_flag_set)
        else $error("flag one missing");
    a_flag_two: assert property (
        second_timer_rollover |=> second_timer_flag_set)
        else $error("flag two missing");
    a_idle_read: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("idle data not zero");
endmodule : adc_trig_checker

bind adc_trigger_and_result_format adc_trig_checker adc_trig_checker_i (.*);

/* tb/testbench.sv */
/*
 * Self-checking bench for the converter slice.
 * Assumes the bound checker and the core model.
 */
`timescale 1ns/10ps
module testbench;
    logic        clk, nrst, reg_write, reg_read, fire, conv_start;
    logic        conv_done, irq;
    logic [3:0]  reg_addr, fire_code, core_wait, irq_en, mbit;
    logic [7:0]  reg_wdata, reg_rdata, seen;
    logic [9:0]  core_value, conversion_result;
    logic [15:0] src;
    logic [1:0]  match_idx;
    int          mismatches, cmp_count, starts;
    assign mbit = 4'h1 << match_idx;
    adc_trigger_and_result_format adc_trigger_and_result_format_i (
        .*,
        .first_timer_rollover(src[3]), .second_timer_rollover(src[4]),
        .third_timer_period_match(src[5]),
        .comparator_synced_output(src[6]),
        .pwm_unit1_match(src[1] ? mbit : 4'h0),
        .pwm_unit2_match(src[2] ? mbit : 4'h0),
        .pwm_unit3_match(src[7] ? mbit : 4'h0),
        .pwm_unit1_irq_enable_set(irq_en),
        .pwm_unit2_irq_enable_set(irq_en),
        .pwm_unit3_irq_enable_set(irq_en),
        .pwm_unit1_offset_hit(src[8]), .pwm_unit2_offset_hit(src[9]),
        .pwm_unit3_offset_hit(src[10]), .converter_on(),
        .input_channel_select(), .conversion_clock_select(),
        .positive_reference_select(), .first_timer_flag_set(),
        .second_timer_flag_set());
    trig_core_model trig_core_model_i (.*);
    // Counts start pulses sent to the core
    always @(posedge clk) begin
        if (conv_start === 1'b1)
            starts <= starts + 1;
    end
    task automatic check(string name, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, e, s);
        end
    endtask : check
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 seen = reg_rdata;
    endtask : rd
    task automatic wait_done;
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < 64) begin
            @(posedge clk);
            #1 n++;
        end
        check("done seen", 8'(n < 64), 8'h01);
        rd(adc_trig_pkg::ADDR_CHANNEL_GO);
        check("go clear", {7'h00, seen[1]}, 8'h00);
    endtask : wait_done
    // Pulses one source for three cycles
    task automatic trig(logic [3:0] sel, logic [3:0] code, logic [7:0] n);
        int s0;
        wr(adc_trig_pkg::ADDR_TRIGGER, {sel, 4'h0});
        s0 = starts;
        @(posedge clk);
        fire <= 1'b1;
        fire_code <= code;
        repeat (3) @(posedge clk);
        fire <= 1'b0;
        repeat (5) @(posedge clk);
        rd(adc_trig_pkg::ADDR_CHANNEL_GO);
        check("go set", {7'h00, seen[1]}, n);
        check("starts", 8'(starts - s0), n);
        if (n != 8'h00)
            wait_done;
    endtask : trig
    task automatic t_regs;
        rd(adc_trig_pkg::ADDR_TRIGGER);
        check("trig reset", seen, 8'h00);
        wr(adc_trig_pkg::ADDR_TRIGGER, 8'hAF);
        rd(adc_trig_pkg::ADDR_TRIGGER);
        check("trig rw", seen, 8'hA0);
        wr(adc_trig_pkg::ADDR_RES_HIGH, 8'h5A);
        wr(adc_trig_pkg::ADDR_RES_LOW, 8'hC3);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rd(adc_trig_pkg::ADDR_RES_HIGH);
        check("res high kept", seen, 8'h5A);
        rd(adc_trig_pkg::ADDR_RES_LOW);
        check("res low kept", seen, 8'hC3);
        rd(adc_trig_pkg::ADDR_TRIGGER);
        check("trig cleared", seen, 8'h00);
        rd(4'h8);
        check("unmapped", seen, 8'h00);
    endtask : t_regs
    // Software start, one layout over preset bytes
    task automatic t_format(logic j);
        logic [7:0] eh, el;
        wr(adc_trig_pkg::ADDR_FORMAT, {j, 7'h00});
        wr(adc_trig_pkg::ADDR_RES_HIGH, 8'hFF);
        wr(adc_trig_pkg::ADDR_RES_LOW, 8'hFF);
        wr(adc_trig_pkg::ADDR_CHANNEL_GO, 8'h03);
        wait_done;
        eh = j ? {6'h00, core_value[9:8]} : core_value[9:2];
        el = j ? core_value[7:0] : {core_value[1:0], 6'h00};
        rd(adc_trig_pkg::ADDR_RES_HIGH);
        check("high", seen, eh);
        rd(adc_trig_pkg::ADDR_RES_LOW);
        check("low", seen, el);
    endtask : t_format
    task automatic t_irq;
        rd(adc_trig_pkg::ADDR_IRQ_STATUS);
        check("status", seen & 8'h03, 8'h03);
        wr(adc_trig_pkg::ADDR_IRQ_CLEAR, 8'h03);
        wr(adc_trig_pkg::ADDR_IRQ_ENABLE, 8'h01);
        core_value <= 10'h2B6;
        t_format(1'b0);
        check("irq on", {7'h00, irq}, 8'h01);
        wr(adc_trig_pkg::ADDR_IRQ_CLEAR, 8'h01);
        wr(adc_trig_pkg::ADDR_IRQ_ENABLE, 8'h00);
        core_value <= 10'h1E9;
        t_format(1'b1);
        check("irq masked", {7'h00, irq}, 8'h00);
        rd(adc_trig_pkg::ADDR_IRQ_STATUS);
        check("status masked", seen & 8'h03, 8'h01);
    endtask : t_irq
    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize;
    end
    initial begin
        {nrst, reg_write, reg_read, fire} = 4'h0;
        {reg_addr, fire_code, match_idx, reg_wdata} = 18'h00000;
        {mismatches, cmp_count, starts} = '0;
        core_value = 10'h3C5;
        core_wait = 4'hF;
        irq_en = 4'h5;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        wr(adc_trig_pkg::ADDR_CHANNEL_GO, 8'h01);
        repeat (20) @(posedge clk);
        for (int c = 1; c <= 10; c++)
            trig(4'(c), 4'(c), 8'h01);
        trig(4'h0, 4'h3, 8'h00);
        match_idx <= 2'h1;
        trig(4'h7, 4'h7, 8'h00);
        match_idx <= 2'h2;
        trig(4'h7, 4'h7, 8'h01);
        wr(adc_trig_pkg::ADDR_CHANNEL_GO, 8'h00);
        trig(4'h3, 4'h3, 8'h00);
        t_irq;
        summarize;
    end
endmodule : testbench

/* tb/trig_core_model.sv */
/*
 * Trigger sources and converter core seen from the slice.
 * Assumes the bench pulses one source by its trigger code.
 */
`timescale 1ns/10ps
module trig_core_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        fire,       // Raise the chosen source
    input  wire logic [3:0]  fire_code,  // Source by trigger code
    input  wire logic [9:0]  core_value, // Next conversion value
    input  wire logic [3:0]  core_wait,  // Conversion length
    input  wire logic        conv_start,
    output logic      [15:0] src,
    output logic             conv_done,
    output logic      [9:0]  conversion_result
);
    logic [3:0] cnt; // Cycles left in a conversion
    // Sources follow fire; core counts then pulses done
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src <= 16'h0000;
            cnt <= 4'h0;
            conv_done <= 1'b0;
            conversion_result <= 10'h000;
        end else begin
            src <= fire ? (16'h0001 << fire_code) : 16'h0000;
            conv_done <= (cnt == 4'h1);
            // Result is only valid beside done, garbage elsewhere
            conversion_result <= (cnt == 4'h1) ? core_value
                                               : ~conversion_result;
            if (conv_start)
                cnt <= core_wait;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule : trig_core_model
